// ===== hdl/cdsar_encoder.v
`timescale 1ns/10ps
`include "cdsar_map.vh"
module cdsar_encoder #(
	parameter SETTLE = `CDSAR_SETTLE_CYCLES
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_start,
	input wire i_comparator,
	input wire i_decode_mode,
	input wire [`CDSAR_WORD_W-1:0] i_decode_word,
	input wire i_decode_ext_bit,
	input wire i_decode_load,
	output wire o_busy,
	output wire o_conversion_done_flag,
	output wire [`CDSAR_WORD_W-1:0] o_result,
	output wire o_mode_select,
	output wire o_polarity_input,
	output wire [`CDSAR_MAG_TOP:0] o_magnitude_bits,
	output wire o_hold_sample
);
	// ****************************************
	// States
	// ****************************************
	// One-hot; WAIT returns to the state kept in after_reg
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_POL = 5'h02;
	localparam [4:0] ST_TRIAL = 5'h04;
	localparam [4:0] ST_DONE = 5'h08;
	localparam [4:0] ST_WAIT = 5'h10;

	// ****************************************
	// Registers and wires
	// ****************************************
	reg [4:0] state_reg, state_next;
	reg [`CDSAR_WORD_W-1:0] sar_reg, sar_next;
	reg [`CDSAR_WORD_W-1:0] trial_reg, trial_next;
	reg [`CDSAR_WORD_W-1:0] result_reg, result_next;
	reg mode_reg, mode_next;
	reg invert_reg, invert_next;
	reg done_reg, done_next;
	// Start clock, polarity cycle plus seven trials, up to nine
	reg [3:0] clocks_reg, clocks_next;
	reg settle_go;
	reg [4:0] after_reg, after_next;
	wire settled;
	wire corrected;
	wire [3:0] settle_cycles;
	wire [`CDSAR_MAG_TOP:0] trial_mag;
	wire [`CDSAR_MAG_TOP:0] trial_lower;
	genvar gi;

	// ****************************************
	// Settle timer
	// ****************************************
	// Cut to the timer width; longer waits need a wider timer
	assign settle_cycles = SETTLE[3:0];

	// Comparator settles on each new code before being sampled
	cdsar_settle #(
		.CNT_W(4)
	) u_settle (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_start(settle_go),
		.i_cycles(settle_cycles),
		.o_done(settled)
	);

	// ****************************************
	// Polarity correction
	// ****************************************
	// Sign 0 marks a negative input, so later verdicts are flipped
	assign corrected = i_comparator ^ invert_reg;

	// ****************************************
	// Trial bits
	// ****************************************
	// Current trial bit takes the verdict, the bit below becomes the trial
	generate
		for (gi = 0; gi <= `CDSAR_MAG_TOP; gi = gi + 1) begin : g_mag
			assign trial_lower[gi] = trial_reg[gi + 1];
			assign trial_mag[gi] = trial_reg[gi] ? corrected : (trial_lower[gi] | sar_reg[gi]);
		end
	endgenerate

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		state_next = state_reg;
		sar_next = sar_reg;
		trial_next = trial_reg;
		result_next = result_reg;
		mode_next = mode_reg;
		invert_next = invert_reg;
		done_next = done_reg;
		clocks_next = clocks_reg;
		after_next = after_reg;
		settle_go = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// Start wins over load; loads while busy are dropped
				if (i_start) begin
					// Clock 1: top bit clear, others set, decode mode
					sar_next = `CDSAR_TRIAL_INIT;
					trial_next = `CDSAR_ZERO_WORD;
					mode_next = `CDSAR_MODE_DECODE;
					invert_next = 1'b0;
					done_next = 1'b0;
					clocks_next = `CDSAR_CLOCK_ONE;
					settle_go = 1'b1;
					after_next = ST_POL;
					state_next = ST_WAIT;
				end else if (i_decode_load) begin
					// Plain decoder use, mode pin as ninth bit while i_decode_mode is low
					sar_next = i_decode_word;
					mode_next = i_decode_mode ? `CDSAR_MODE_DECODE : i_decode_ext_bit;
				end
			end
			ST_WAIT: begin
				// Nothing moves while the converter output settles
				if (settled)
					state_next = after_reg;
			end
			ST_POL: begin
				// Clock 2: sign captured, encode mode back on
				sar_next[`CDSAR_SIGN_BIT] = corrected;
				invert_next = ~corrected;
				mode_next = `CDSAR_MODE_ENCODE;
				trial_next = `CDSAR_BIT_ONE << `CDSAR_MAG_TOP;
				sar_next[`CDSAR_MAG_TOP-1:0] = {`CDSAR_MAG_TOP{1'b0}};
				sar_next[`CDSAR_MAG_TOP] = 1'b1;
				clocks_next = clocks_reg + `CDSAR_CLOCK_ONE;
				settle_go = 1'b1;
				after_next = ST_TRIAL;
				state_next = ST_WAIT;
			end
			ST_TRIAL: begin
				// Trial bit kept when corrected comparator says input above
				sar_next = {sar_reg[`CDSAR_SIGN_BIT], trial_mag};
				trial_next = {1'b0, trial_lower};
				clocks_next = clocks_reg + `CDSAR_CLOCK_ONE;
				if (clocks_reg + `CDSAR_CLOCK_ONE == `CDSAR_CONV_CLOCKS) begin
					state_next = ST_DONE;
				end else begin
					settle_go = 1'b1;
					after_next = ST_TRIAL;
					state_next = ST_WAIT;
				end
			end
			ST_DONE: begin
				// Copied once, so the result never shows a half-done code
				result_next = sar_reg;
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: begin
				// Stray code falls back to idle
				state_next = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// Converter left in decode mode, encode outputs dark
			state_reg <= ST_IDLE;
			sar_reg <= `CDSAR_ZERO_WORD;
			trial_reg <= `CDSAR_ZERO_WORD;
			result_reg <= `CDSAR_ZERO_WORD;
			mode_reg <= `CDSAR_MODE_DECODE;
			invert_reg <= 1'b0;
			done_reg <= 1'b0;
			clocks_reg <= 4'h0;
			after_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
			sar_reg <= sar_next;
			trial_reg <= trial_next;
			result_reg <= result_next;
			mode_reg <= mode_next;
			invert_reg <= invert_next;
			done_reg <= done_next;
			clocks_reg <= clocks_next;
			after_reg <= after_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_busy = (state_reg != ST_IDLE);
	// Input must not move while trials run, so hold spans busy
	assign o_hold_sample = o_busy;
	assign o_conversion_done_flag = done_reg;
	assign o_result = result_reg;
	assign o_mode_select = mode_reg;
	assign o_polarity_input = sar_reg[`CDSAR_SIGN_BIT];
	assign o_magnitude_bits = sar_reg[`CDSAR_MAG_TOP:0];
endmodule

// ===== hdl/cdsar_map.vh
`ifndef CDSAR_MAP_VH
`define CDSAR_MAP_VH
// ****************************************
// Bit widths and positions
// ****************************************
`define CDSAR_WORD_W 8
`define CDSAR_SIGN_BIT 7
`define CDSAR_CHORD_HI 6
`define CDSAR_CHORD_LO 4
`define CDSAR_STEP_HI 3
`define CDSAR_STEP_LO 0
`define CDSAR_MAG_TOP 6
// ****************************************
// Values
// ****************************************
`define CDSAR_TRIAL_INIT 8'h7F
`define CDSAR_ZERO_WORD 8'h00
`define CDSAR_MODE_ENCODE 1'b1
`define CDSAR_MODE_DECODE 1'b0
`define CDSAR_CONV_CLOCKS 4'h9
`define CDSAR_SETTLE_CYCLES 4'h1
`define CDSAR_BIT_ONE 8'h01
`define CDSAR_CLOCK_ONE 4'h1
`endif

// ===== hdl/cdsar_settle.v
`timescale 1ns/10ps
// ****************************************
// Settle timer: one-cycle strobe after a programmable wait
// ****************************************
module cdsar_settle #(
	parameter CNT_W = 4
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_start,
	input wire [CNT_W-1:0] i_cycles,
	output wire o_done
);
	reg [CNT_W-1:0] cnt_reg;
	reg run_reg;
	reg done_reg;
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_reg <= {CNT_W{1'b0}};
			run_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (i_start) begin
				cnt_reg <= i_cycles;
				run_reg <= 1'b1;
			end else if (run_reg) begin
				if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
					run_reg <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
	assign o_done = done_reg;
endmodule

// ===== bench/cdsar_monitor.sv
`timescale 1ns/10ps
module cdsar_monitor (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_start,
	input wire i_comparator,
	input wire o_busy,
	input wire o_conversion_done_flag,
	input wire [7:0] o_result,
	input wire o_mode_select,
	input wire o_polarity_input,
	input wire [6:0] o_magnitude_bits,
	input wire o_hold_sample
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_go; $rose(o_busy); endsequence
	sequence s_sign; $rose(o_mode_select) && o_busy; endsequence
	hold_follow_a: assert property (o_hold_sample == o_busy) else $error("hold");
	first_clock_a: assert property (
		s_go |-> !o_mode_select && o_magnitude_bits == 7'h7F) else $error("first");
	sign_latch_a: assert property (
		s_sign |-> o_polarity_input == $past(i_comparator) && o_magnitude_bits == 7'h40)
		else $error("sign");
	start_take_a: assert property (
		!o_busy && i_start |=> o_busy && !o_conversion_done_flag) else $error("start");
	mode_stay_a: assert property (
		o_busy && o_mode_select |=> o_mode_select || !o_busy) else $error("mode");
	conv_length_a: assert property (s_go |-> ##[18:40] $fell(o_busy)) else $error("len");
	done_flag_a: assert property (
		$fell(o_busy) |-> ##[0:1] o_conversion_done_flag) else $error("done");
	result_hold_a: assert property (
		o_conversion_done_flag && !i_start |=> $stable(o_result)) else $error("keep");
endmodule
bind cdsar_encoder cdsar_monitor u_mon (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_start(i_start),
	.i_comparator(i_comparator),
	.o_busy(o_busy),
	.o_conversion_done_flag(o_conversion_done_flag),
	.o_result(o_result),
	.o_mode_select(o_mode_select),
	.o_polarity_input(o_polarity_input),
	.o_magnitude_bits(o_magnitude_bits),
	.o_hold_sample(o_hold_sample)
);

// ===== bench/cdsar_conv_model.sv
`timescale 1ns/10ps
module cdsar_conv_model (
	input wire i_mode,
	input wire i_sign,
	input wire [6:0] i_mag,
	input integer i_ain,
	output wire o_cmp
);
	integer lvl;
	// Doubled units so the encode half step stays whole
	always @* begin
		lvl = (2 << i_mag[6:4]) * (2 * i_mag[3:0] + 34) - 66;
	end
	// Encode outputs dark while mode low, so input meets ground
	assign o_cmp = !i_mode ? i_ain > 0 : (i_sign ? i_ain > lvl : i_ain > -lvl);
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	reg i_clk = 0;
	reg i_reset_n = 0;
	reg i_start = 0;
	reg i_decode_mode = 1;
	reg [7:0] i_decode_word = 8'h00;
	reg i_decode_ext_bit = 0;
	reg i_decode_load = 0;
	integer ain = 0;
	integer n_fail = 0;
	integer cmp_count = 0;
	integer ticks = 0;
	integer k, r;
	wire i_comparator, o_busy, o_conversion_done_flag, o_mode_select, o_polarity_input;
	wire o_hold_sample;
	wire [7:0] o_result;
	wire [6:0] o_magnitude_bits;
	integer row_ain [0:5] = '{100000, -100000, 0, 1, 71, -71};
	reg [7:0] row_res [0:5] = '{8'hFF, 8'h7F, 8'h00, 8'h80, 8'h90, 8'h10};
	cdsar_encoder u_dut (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_start(i_start),
		.i_comparator(i_comparator),
		.i_decode_mode(i_decode_mode),
		.i_decode_word(i_decode_word),
		.i_decode_ext_bit(i_decode_ext_bit),
		.i_decode_load(i_decode_load),
		.o_busy(o_busy),
		.o_conversion_done_flag(o_conversion_done_flag),
		.o_result(o_result),
		.o_mode_select(o_mode_select),
		.o_polarity_input(o_polarity_input),
		.o_magnitude_bits(o_magnitude_bits),
		.o_hold_sample(o_hold_sample)
	);
	cdsar_conv_model u_conv (.i_mode(o_mode_select), .i_sign(o_polarity_input),
		.i_mag(o_magnitude_bits), .i_ain(ain), .o_cmp(i_comparator));
	initial forever #25 i_clk = ~i_clk;
	task check(input [8:0] got, input [8:0] want);
		begin
			cmp_count = cmp_count + 1;
			if (got !== want) begin
				n_fail = n_fail + 1;
				$display("Error %0t: %h not %h", $time, got, want);
			end
		end
	endtask
	task wrap_up;
		begin
			if (n_fail == 0 && cmp_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	always @(posedge i_clk) begin
		ticks = ticks + 1;
		if (ticks == 3000) begin
			n_fail = n_fail + 1;
			wrap_up;
		end
	end
	task run_conv(input integer a);
		begin
			ain <= a;
			i_start <= 1;
			@(posedge i_clk);
			i_start <= 0;
			@(posedge i_clk);
			for (k = 0; k < 60 && o_conversion_done_flag !== 1'b1; k = k + 1)
				@(posedge i_clk);
		end
	endtask
	task load_dec(input m, input e, input [7:0] w);
		begin
			i_decode_mode <= m;
			i_decode_ext_bit <= e;
			i_decode_word <= w;
			i_decode_load <= 1;
			@(posedge i_clk);
			i_decode_load <= 0;
			@(posedge i_clk);
		end
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1;
		for (r = 0; r < 6; r = r + 1) begin
			run_conv(row_ain[r]);
			check(o_result, row_res[r]);
			check(o_conversion_done_flag, 9'h001);
		end
		// Load while converting is dropped
		ain <= 71;
		i_start <= 1;
		@(posedge i_clk);
		i_start <= 0;
		load_dec(0, 0, 8'h00);
		for (k = 0; k < 60 && o_conversion_done_flag !== 1'b1; k = k + 1)
			@(posedge i_clk);
		check(o_result, 9'h090);
		check({o_mode_select, o_polarity_input, o_magnitude_bits}, 9'h190);
		// Decode-only use: mode pin carries the ninth bit only while i_decode_mode is low
		load_dec(0, 1, 8'hA5);
		check({o_mode_select, o_polarity_input, o_magnitude_bits}, 9'h1A5);
		load_dec(0, 0, 8'h5A);
		check({o_mode_select, o_polarity_input, o_magnitude_bits}, 9'h05A);
		load_dec(1, 1, 8'hC3);
		check({o_mode_select, o_polarity_input, o_magnitude_bits}, 9'h0C3);
		// Reset in mid-conversion, then a clean conversion
		ain <= 100000;
		i_start <= 1;
		@(posedge i_clk);
		i_start <= 0;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 0;
		@(posedge i_clk);
		check({o_busy, o_hold_sample, o_conversion_done_flag, o_mode_select}, 9'h000);
		check(o_result, 9'h000);
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1;
		run_conv(-71);
		check(o_result, 9'h010);
		wrap_up;
	end
endmodule
